//--- core/acysm_mailbox.sv
// acyclic service mailbox: request and response spaces, status table
`timescale 1ns/1ps
`default_nettype none
module acysm_mailbox #(
    parameter int PAY_WORDS = 123,
    parameter int NODES = 100
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic svc_busy,
    output logic svc_req_valid,
    input wire logic svc_req_ready,
    output logic [7:0] svc_access,
    output logic [7:0] svc_object,
    output logic [7:0] svc_node,
    output logic [7:0] svc_length,
    input wire logic [6:0] pay_rd_idx,
    output logic [15:0] pay_rd_word,
    input wire logic res_wr_en,
    input wire logic [6:0] res_wr_idx,
    input wire logic [15:0] res_wr_word,
    input wire logic svc_done,
    input wire logic [15:0] svc_result,
    input wire logic [7:0] svc_res_length,
    input wire logic stat_upd_en,
    input wire logic [6:0] stat_upd_node,
    input wire logic stat_pending_a,
    input wire logic stat_node_present,
    input wire logic stat_placeholder_fitted,
    input wire logic cyc_valid,
    input wire logic [6:0] cyc_node,
    input wire logic [7:0] cyc_byte_raw,
    output logic [7:0] cyc_byte_out,
    output logic cyc_byte_valid
);
    acysm_pkg::acysm_state_t state;
    logic [15:0] request_tag;
    logic [15:0] request_object_and_access;
    logic [15:0] request_target_and_slot;
    logic [15:0] request_length;
    logic [15:0] request_payload [PAY_WORDS];
    logic [15:0] response_tag;
    logic [15:0] response_result;
    logic [15:0] response_object_and_access;
    logic [15:0] response_target_and_slot;
    logic [15:0] response_length;
    logic [15:0] response_payload [PAY_WORDS];
    logic [3:0] tbl_rd_nibble;
    logic [15:0] next_result;
    logic tag_write;

    function automatic logic in_span(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [6:0] span_idx(input logic [15:0] a,
                                            input logic [15:0] lo);
        logic [15:0] d;
        d = a - lo;
        return d[6:0];
    endfunction

    // request space is frozen while a service runs, so the field engine
    // sees stable parameters and data throughout
    assign tag_write = reg_wr_en && (reg_addr == acysm_pkg::REQ_TAG_OFS)
                       && (state == acysm_pkg::ST_IDLE);

    // unknown access is reported ahead of parameter checks
    always_comb begin
        next_result = acysm_pkg::RESULT_OK;
        case (request_object_and_access[15:8])
            acysm_pkg::ACC_NOP,
            acysm_pkg::ACC_READ,
            acysm_pkg::ACC_WRITE: begin
                if (request_target_and_slot[7:0] > acysm_pkg::MAX_NODE
                    || request_target_and_slot[15:8]
                       != acysm_pkg::SLOT_VALUE
                    || request_length > {8'h00, acysm_pkg::MAX_LENGTH}) begin
                    next_result = acysm_pkg::RESULT_BAD_PARAMS;
                end
            end
            default: begin
                next_result = acysm_pkg::RESULT_UNKNOWN_ACCESS;
            end
        endcase
    end

    // request space writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            request_object_and_access <= acysm_pkg::WORD_RESET;
            request_target_and_slot <= acysm_pkg::WORD_RESET;
            request_length <= acysm_pkg::WORD_RESET;
            for (int i = 0; i < PAY_WORDS; i++) begin
                request_payload[i] <= acysm_pkg::WORD_RESET;
            end
        end else if (reg_wr_en && state == acysm_pkg::ST_IDLE) begin
            if (reg_addr == acysm_pkg::REQ_OBJ_ACC_OFS) begin
                request_object_and_access <= reg_wr_data;
            end
            if (reg_addr == acysm_pkg::REQ_TARGET_OFS) begin
                request_target_and_slot <= reg_wr_data;
            end
            if (reg_addr == acysm_pkg::REQ_LEN_OFS) begin
                request_length <= reg_wr_data;
            end
            if (in_span(reg_addr, acysm_pkg::REQ_PAY_OFS,
                        acysm_pkg::REQ_PAY_END)) begin
                request_payload[span_idx(reg_addr,
                                         acysm_pkg::REQ_PAY_OFS)]
                    <= reg_wr_data;
            end
        end
    end

    // request tag: written by the client, cleared at completion
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            request_tag <= acysm_pkg::WORD_RESET;
        end else if (tag_write) begin
            request_tag <= reg_wr_data;
        end else if (state == acysm_pkg::ST_FINISH) begin
            request_tag <= acysm_pkg::WORD_RESET;
        end
    end

    // service sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= acysm_pkg::ST_IDLE;
        end else begin
            case (state)
                acysm_pkg::ST_IDLE: begin
                    if (tag_write) begin
                        state <= acysm_pkg::ST_ISSUE;
                    end
                end
                acysm_pkg::ST_ISSUE: begin
                    // no-op and rejected requests never reach the line
                    if (next_result != acysm_pkg::RESULT_OK
                        || request_object_and_access[15:8]
                           == acysm_pkg::ACC_NOP) begin
                        state <= acysm_pkg::ST_FINISH;
                    end else if (svc_req_valid && svc_req_ready) begin
                        state <= acysm_pkg::ST_WAIT;
                    end
                end
                acysm_pkg::ST_WAIT: begin
                    if (svc_done) begin
                        state <= acysm_pkg::ST_FINISH;
                    end
                end
                acysm_pkg::ST_FINISH: begin
                    state <= acysm_pkg::ST_IDLE;
                end
                default: begin
                    state <= acysm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request toward the field engine
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            svc_req_valid <= 1'b0;
            svc_access <= acysm_pkg::BYTE_RESET;
            svc_object <= acysm_pkg::BYTE_RESET;
            svc_node <= acysm_pkg::BYTE_RESET;
            svc_length <= acysm_pkg::BYTE_RESET;
        end else begin
            if (tag_write) begin
                svc_access <= request_object_and_access[15:8];
                svc_object <= request_object_and_access[7:0];
                svc_node <= request_target_and_slot[7:0];
                svc_length <= request_length[7:0];
            end
            if (state == acysm_pkg::ST_ISSUE && !svc_req_valid
                && next_result == acysm_pkg::RESULT_OK
                && (request_object_and_access[15:8] == acysm_pkg::ACC_READ
                    || request_object_and_access[15:8]
                       == acysm_pkg::ACC_WRITE)) begin
                svc_req_valid <= 1'b1;
            end else if (svc_req_ready) begin
                svc_req_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            svc_busy <= 1'b0;
        end else if (tag_write) begin
            svc_busy <= 1'b1;
        end else if (state == acysm_pkg::ST_FINISH) begin
            svc_busy <= 1'b0;
        end
    end

    // write data handed out one cycle after the index
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pay_rd_word <= acysm_pkg::WORD_RESET;
        end else if (int'(pay_rd_idx) < PAY_WORDS) begin
            pay_rd_word <= request_payload[pay_rd_idx];
        end else begin
            pay_rd_word <= acysm_pkg::WORD_RESET;
        end
    end

    // response space; the tag is written last as the completion mark
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            response_tag <= acysm_pkg::WORD_RESET;
            response_result <= acysm_pkg::WORD_RESET;
            response_object_and_access <= acysm_pkg::WORD_RESET;
            response_target_and_slot <= acysm_pkg::WORD_RESET;
            response_length <= acysm_pkg::WORD_RESET;
        end else begin
            case (state)
                acysm_pkg::ST_IDLE: begin
                    if (tag_write) begin
                        response_object_and_access
                            <= request_object_and_access;
                        response_target_and_slot
                            <= request_target_and_slot;
                    end
                end
                acysm_pkg::ST_ISSUE: begin
                    if (next_result != acysm_pkg::RESULT_OK
                        || request_object_and_access[15:8]
                           == acysm_pkg::ACC_NOP) begin
                        response_result <= next_result;
                        response_length <= acysm_pkg::WORD_RESET;
                    end
                end
                acysm_pkg::ST_WAIT: begin
                    if (svc_done) begin
                        response_result <= svc_result;
                        // clamp so a bad count never points past the area
                        if (svc_res_length > acysm_pkg::MAX_LENGTH) begin
                            response_length
                                <= {8'h00, acysm_pkg::MAX_LENGTH};
                        end else begin
                            response_length <= {8'h00, svc_res_length};
                        end
                    end
                end
                acysm_pkg::ST_FINISH: begin
                    response_tag <= request_tag;
                end
                default: begin
                    response_tag <= response_tag;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < PAY_WORDS; i++) begin
                response_payload[i] <= acysm_pkg::WORD_RESET;
            end
        end else if (res_wr_en && state == acysm_pkg::ST_WAIT
                     && int'(res_wr_idx) < PAY_WORDS) begin
            response_payload[res_wr_idx] <= res_wr_word;
        end
    end

    acysm_status_table #(
        .NODES(NODES)
    ) u_status_table (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .stat_upd_en(stat_upd_en),
        .stat_upd_node(stat_upd_node),
        .stat_pending_a(stat_pending_a),
        .stat_node_present(stat_node_present),
        .stat_placeholder_fitted(stat_placeholder_fitted),
        .tbl_rd_idx(span_idx(reg_addr, acysm_pkg::STAT_TBL_OFS)),
        .tbl_rd_nibble(tbl_rd_nibble),
        .cyc_valid(cyc_valid),
        .cyc_node(cyc_node),
        .cyc_byte_raw(cyc_byte_raw),
        .cyc_byte_out(cyc_byte_out),
        .cyc_byte_valid(cyc_byte_valid)
    );

    // register reads answer one cycle later; unmapped words read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rd_data <= acysm_pkg::WORD_RESET;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                if (in_span(reg_addr, acysm_pkg::STAT_TBL_OFS,
                            acysm_pkg::STAT_TBL_END)) begin
                    reg_rd_data <= {12'h000, tbl_rd_nibble};
                end else if (in_span(reg_addr, acysm_pkg::REQ_PAY_OFS,
                                     acysm_pkg::REQ_PAY_END)) begin
                    reg_rd_data <= request_payload[span_idx(reg_addr,
                        acysm_pkg::REQ_PAY_OFS)];
                end else if (in_span(reg_addr, acysm_pkg::RSP_PAY_OFS,
                                     acysm_pkg::RSP_PAY_END)) begin
                    reg_rd_data <= response_payload[span_idx(reg_addr,
                        acysm_pkg::RSP_PAY_OFS)];
                end else begin
                    case (reg_addr)
                        acysm_pkg::REQ_TAG_OFS:
                            reg_rd_data <= request_tag;
                        acysm_pkg::REQ_OBJ_ACC_OFS:
                            reg_rd_data <= request_object_and_access;
                        acysm_pkg::REQ_TARGET_OFS:
                            reg_rd_data <= request_target_and_slot;
                        acysm_pkg::REQ_LEN_OFS:
                            reg_rd_data <= request_length;
                        acysm_pkg::RSP_TAG_OFS:
                            reg_rd_data <= response_tag;
                        acysm_pkg::RSP_RESULT_OFS:
                            reg_rd_data <= response_result;
                        acysm_pkg::RSP_OBJ_ACC_OFS:
                            reg_rd_data <= response_object_and_access;
                        acysm_pkg::RSP_TARGET_OFS:
                            reg_rd_data <= response_target_and_slot;
                        acysm_pkg::RSP_LEN_OFS:
                            reg_rd_data <= response_length;
                        default:
                            reg_rd_data <= acysm_pkg::WORD_RESET;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- core/acysm_pkg.sv
// constants shared by the acyclic service mailbox and its status table
package acysm_pkg;
    // register map, word offsets on the register port
    localparam logic [15:0] STAT_TBL_OFS = 16'h1300;
    localparam logic [15:0] STAT_TBL_END = 16'h137f;
    localparam logic [15:0] REQ_TAG_OFS = 16'h8000;
    localparam logic [15:0] REQ_OBJ_ACC_OFS = 16'h8002;
    localparam logic [15:0] REQ_TARGET_OFS = 16'h8003;
    localparam logic [15:0] REQ_LEN_OFS = 16'h8004;
    localparam logic [15:0] REQ_PAY_OFS = 16'h8005;
    localparam logic [15:0] REQ_PAY_END = 16'h807f;
    localparam logic [15:0] RSP_TAG_OFS = 16'h8080;
    localparam logic [15:0] RSP_RESULT_OFS = 16'h8081;
    localparam logic [15:0] RSP_OBJ_ACC_OFS = 16'h8082;
    localparam logic [15:0] RSP_TARGET_OFS = 16'h8083;
    localparam logic [15:0] RSP_LEN_OFS = 16'h8084;
    localparam logic [15:0] RSP_PAY_OFS = 16'h8085;
    localparam logic [15:0] RSP_PAY_END = 16'h80ff;

    // sizes
    localparam int PAYLOAD_WORDS = 123;
    localparam int NODE_COUNT = 100;
    localparam logic [7:0] MAX_NODE = 8'h63;
    localparam logic [7:0] MAX_LENGTH = 8'h78;
    localparam logic [7:0] SLOT_VALUE = 8'h00;

    // access codes
    localparam logic [7:0] ACC_NOP = 8'h00;
    localparam logic [7:0] ACC_READ = 8'h03;
    localparam logic [7:0] ACC_WRITE = 8'h10;

    // result codes
    localparam logic [15:0] RESULT_OK = 16'h0000;
    localparam logic [15:0] RESULT_BAD_PARAMS = 16'hfffe;
    localparam logic [15:0] RESULT_UNKNOWN_ACCESS = 16'hffff;

    // status flag positions in the cyclic first input byte
    localparam int PENDING_A_BIT = 4;
    localparam int NODE_PRESENT_BIT = 6;
    localparam int PLACEHOLDER_BIT = 7;

    // values after reset
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_FINISH
    } acysm_state_t;
endpackage

//--- core/acysm_status_table.sv
// per-node status flags: read-only table and cyclic input byte merge
`timescale 1ns/1ps
`default_nettype none
module acysm_status_table #(
    parameter int NODES = 100
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic stat_upd_en,
    input wire logic [6:0] stat_upd_node,
    input wire logic stat_pending_a,
    input wire logic stat_node_present,
    input wire logic stat_placeholder_fitted,
    input wire logic [6:0] tbl_rd_idx,
    output logic [3:0] tbl_rd_nibble,
    input wire logic cyc_valid,
    input wire logic [6:0] cyc_node,
    input wire logic [7:0] cyc_byte_raw,
    output logic [7:0] cyc_byte_out,
    output logic cyc_byte_valid
);
    logic [NODES-1:0] pending_a;
    logic [NODES-1:0] node_present;
    logic [NODES-1:0] placeholder_fitted;

    // flags follow the field engine as levels, set and clear alike
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pending_a <= '0;
            node_present <= '0;
            placeholder_fitted <= '0;
        end else if (stat_upd_en && int'(stat_upd_node) < NODES) begin
            pending_a[stat_upd_node] <= stat_pending_a;
            node_present[stat_upd_node] <= stat_node_present;
            placeholder_fitted[stat_upd_node] <= stat_placeholder_fitted;
        end
    end

    function automatic logic [3:0] status_of(input logic [6:0] idx);
        logic [3:0] v;
        v = 4'h0;
        if (int'(idx) < NODES) begin
            v[acysm_pkg::PLACEHOLDER_BIT-4] = placeholder_fitted[idx];
            v[acysm_pkg::NODE_PRESENT_BIT-4] = node_present[idx];
            v[acysm_pkg::PENDING_A_BIT-4] = pending_a[idx];
        end
        return v;
    endfunction

    // unused slots past the last node read as zero
    always_comb begin
        tbl_rd_nibble = status_of(tbl_rd_idx);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cyc_byte_out <= acysm_pkg::BYTE_RESET;
            cyc_byte_valid <= 1'b0;
        end else begin
            cyc_byte_valid <= cyc_valid;
            if (cyc_valid) begin
                // an absent node delivers all-zero input data
                if (int'(cyc_node) < NODES && node_present[cyc_node]) begin
                    cyc_byte_out <= {status_of(cyc_node),
                                     cyc_byte_raw[3:0]};
                end else begin
                    cyc_byte_out <= acysm_pkg::BYTE_RESET;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test/acysm_mailbox_chk.sv
// port assertions for the service mailbox
`timescale 1ns/1ps
`default_nettype none
module acysm_mailbox_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd_valid,
    input wire logic svc_busy,
    input wire logic svc_req_valid,
    input wire logic svc_req_ready,
    input wire logic [7:0] svc_access,
    input wire logic svc_done,
    input wire logic cyc_valid,
    input wire logic [6:0] cyc_node,
    input wire logic [7:0] cyc_byte_out,
    input wire logic cyc_byte_valid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_read_answer_lat: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read answer not one cycle later");
    a_tag_starts_busy: assert property (reg_wr_en && !svc_busy
        && reg_addr == acysm_pkg::REQ_TAG_OFS |=> svc_busy)
        else $error("tag write did not start a service");
    a_cyc_byte_lat: assert property (cyc_valid |=> cyc_byte_valid)
        else $error("cyclic byte answer missing");
    a_absent_node_zero: assert property (cyc_valid && cyc_node > 7'd99
        |=> cyc_byte_out == 8'h00)
        else $error("node >= 100 gave data");
    a_unused_bit_zero: assert property (
        cyc_byte_valid |-> !cyc_byte_out[5])
        else $error("status bit 5 set");
    a_req_holds_fields: assert property (svc_req_valid && !svc_req_ready
        |=> svc_req_valid && $stable(svc_access))
        else $error("request dropped before ready");
    a_nop_timing: assert property ($rose(svc_busy)
        && svc_access == acysm_pkg::ACC_NOP |-> ##1 svc_busy ##1 !svc_busy)
        else $error("no-op timing wrong");
    a_done_completes: assert property (svc_done && svc_busy
        && !svc_req_valid |=> svc_busy ##[1:2] !svc_busy)
        else $error("no completion after done");
    c_req_taken: cover property (svc_req_valid && svc_req_ready);
    c_done_seen: cover property (svc_done && svc_busy);
    c_cyc_flags: cover property (cyc_byte_valid && cyc_byte_out != 8'h00);
endmodule
bind acysm_mailbox acysm_mailbox_chk u_chk (.core_clk, .sys_rst, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_rd_valid, .svc_busy, .svc_req_valid,
    .svc_req_ready, .svc_access, .svc_done, .cyc_valid, .cyc_node,
    .cyc_byte_out, .cyc_byte_valid);
`default_nettype wire

//--- test/acysm_field_model.sv
// field engine stand-in: takes service requests and answers them
`timescale 1ns/1ps
`default_nettype none
module acysm_field_model (
    input wire logic core_clk,
    input wire logic [3:0] lat,
    input wire logic svc_req_valid,
    input wire logic [7:0] svc_length,
    input wire logic [15:0] pay_rd_word,
    output logic svc_req_ready,
    output logic [6:0] pay_rd_idx,
    output logic res_wr_en,
    output logic [6:0] res_wr_idx,
    output logic [15:0] res_wr_word,
    output logic svc_done,
    output logic [15:0] svc_result,
    output logic [7:0] svc_res_length
);
    initial begin
        {svc_req_ready, res_wr_en, svc_done, pay_rd_idx, res_wr_idx} = '0;
        {res_wr_word, svc_result, svc_res_length} = '0;
        forever begin
            @(negedge core_clk);
            // idle data toggles
            res_wr_word = ~res_wr_word;
            svc_result = ~svc_result;
            if (svc_req_valid) begin
                repeat (lat) @(negedge core_clk);
                svc_req_ready = 1'b1;
                @(negedge core_clk);
                svc_req_ready = 1'b0;
                @(negedge core_clk);
                res_wr_en = 1'b1;
                res_wr_word = pay_rd_word + 16'h0001;
                @(negedge core_clk);
                res_wr_en = 1'b0;
                svc_done = 1'b1;
                svc_result = acysm_pkg::RESULT_OK;
                svc_res_length = svc_length;
                @(negedge core_clk);
                svc_done = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the acyclic service mailbox
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, svc_busy;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data, pay_rd_word;
    logic [15:0] res_wr_word, svc_result;
    logic svc_req_valid, svc_req_ready, res_wr_en, svc_done, stat_upd_en;
    logic [7:0] svc_access, svc_object, svc_node, svc_length, svc_res_length;
    logic [6:0] pay_rd_idx, res_wr_idx, stat_upd_node, cyc_node;
    logic stat_pending_a, stat_node_present, stat_placeholder_fitted;
    logic cyc_valid, cyc_byte_valid;
    logic [7:0] cyc_byte_raw, cyc_byte_out;
    logic [3:0] lat;
    int errors, n_compared;
    acysm_mailbox uut (.core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wr_data, .reg_rd_data, .reg_rd_valid, .svc_busy, .svc_req_valid,
        .svc_req_ready, .svc_access, .svc_object, .svc_node, .svc_length,
        .pay_rd_idx, .pay_rd_word, .res_wr_en, .res_wr_idx, .res_wr_word,
        .svc_done, .svc_result, .svc_res_length, .stat_upd_en, .stat_upd_node,
        .stat_pending_a, .stat_node_present, .stat_placeholder_fitted,
        .cyc_valid, .cyc_node, .cyc_byte_raw, .cyc_byte_out, .cyc_byte_valid);
    acysm_field_model u_field (.core_clk, .lat, .svc_req_valid, .svc_length,
        .pay_rd_word, .svc_req_ready, .pay_rd_idx, .res_wr_en, .res_wr_idx,
        .res_wr_word, .svc_done, .svc_result, .svc_res_length);
    task automatic close_out;
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        @(negedge core_clk);
        {reg_rd_en, reg_addr} = {1'b1, a};
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        chk({15'h0, reg_rd_valid}, 16'h0001);
        chk(reg_rd_data, e);
    endtask
    task automatic t_service(input logic [7:0] acc, obj, node, slot, len,
        input logic [15:0] tag, res);
        int i;
        logic ok;
        ok = res === acysm_pkg::RESULT_OK && acc !== acysm_pkg::ACC_NOP;
        wr(acysm_pkg::REQ_PAY_OFS, 16'h1234);
        wr(acysm_pkg::REQ_OBJ_ACC_OFS, {acc, obj});
        wr(acysm_pkg::REQ_TARGET_OFS, {slot, node});
        wr(acysm_pkg::REQ_LEN_OFS, {8'h00, len});
        wr(acysm_pkg::REQ_TAG_OFS, tag);
        wr(acysm_pkg::REQ_LEN_OFS, 16'h00ff); // dropped while busy
        for (i = 0; i < 40 && reg_rd_data !== tag; i++) begin
            @(negedge core_clk);
            {reg_rd_en, reg_addr} = {1'b1, acysm_pkg::RSP_TAG_OFS};
            @(negedge core_clk);
            reg_rd_en = 1'b0;
        end
        chk(reg_rd_data, tag);
        chk({svc_object, svc_node}, {obj, node});
        rdc(acysm_pkg::REQ_TAG_OFS, 16'h0000);
        rdc(acysm_pkg::RSP_RESULT_OFS, res);
        rdc(acysm_pkg::RSP_OBJ_ACC_OFS, {acc, obj});
        rdc(acysm_pkg::RSP_TARGET_OFS, {slot, node});
        rdc(acysm_pkg::REQ_LEN_OFS, {8'h00, len});
        rdc(acysm_pkg::RSP_LEN_OFS, ok ? {8'h00, len} : 16'h0000);
        if (ok) rdc(acysm_pkg::RSP_PAY_OFS, 16'h1235);
    endtask
    task automatic upd(input logic [6:0] n, input logic pa, pr, pl);
        @(negedge core_clk);
        {stat_upd_en, stat_upd_node} = {1'b1, n};
        {stat_pending_a, stat_node_present, stat_placeholder_fitted} =
            {pa, pr, pl};
        @(negedge core_clk);
        stat_upd_en = 1'b0;
    endtask
    task automatic cyc(input logic [6:0] n, input logic [7:0] raw, e);
        @(negedge core_clk);
        {cyc_valid, cyc_node, cyc_byte_raw} = {1'b1, n, raw};
        @(negedge core_clk);
        cyc_valid = 1'b0;
        chk({15'h0, cyc_byte_valid}, 16'h0001);
        chk({8'h00, cyc_byte_out}, {8'h00, e});
    endtask
    task automatic t_reset;
        rdc(acysm_pkg::RSP_TAG_OFS, 16'h0000);
        rdc(16'h9000, 16'h0000);
        wr(acysm_pkg::RSP_RESULT_OFS, 16'h5555); // read-only place
        rdc(acysm_pkg::RSP_RESULT_OFS, 16'h0000);
    endtask
    task automatic t_status;
        upd(7'd7, 1'b1, 1'b1, 1'b1);
        rdc(acysm_pkg::STAT_TBL_OFS + 16'd7, 16'h000d);
        cyc(7'd7, 8'h5a, 8'hda);
        upd(7'd7, 1'b1, 1'b0, 1'b0);
        wr(acysm_pkg::STAT_TBL_OFS + 16'd7, 16'h000f);
        rdc(acysm_pkg::STAT_TBL_OFS + 16'd7, 16'h0001);
        cyc(7'd7, 8'h5a, 8'h00);
        upd(7'd99, 1'b0, 1'b1, 1'b0);
        rdc(acysm_pkg::STAT_TBL_OFS + 16'd99, 16'h0004);
        cyc(7'd99, 8'hff, 8'h4f);
        upd(7'd100, 1'b1, 1'b1, 1'b1);
        rdc(acysm_pkg::STAT_TBL_OFS + 16'd100, 16'h0000);
        cyc(7'd100, 8'hff, 8'h00);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end
    initial begin
        {errors, n_compared, sys_rst, lat} = {32'd0, 32'd0, 1'b1, 4'h0};
        {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data, stat_upd_en} = '0;
        {stat_upd_node, stat_pending_a, stat_node_present} = '0;
        {stat_placeholder_fitted, cyc_valid, cyc_node, cyc_byte_raw} = '0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_service(acysm_pkg::ACC_READ, 8'h12, 8'd5, 8'h00, 8'd2, 16'ha501,
            acysm_pkg::RESULT_OK);
        lat = 4'h6;
        t_service(acysm_pkg::ACC_WRITE, 8'h34, 8'd99, 8'h00, 8'd120,
            16'ha502, acysm_pkg::RESULT_OK);
        t_service(acysm_pkg::ACC_NOP, 8'h01, 8'd3, 8'h00, 8'd4, 16'ha503,
            acysm_pkg::RESULT_OK);
        t_service(8'h07, 8'h01, 8'd3, 8'h00, 8'd1, 16'ha504,
            acysm_pkg::RESULT_UNKNOWN_ACCESS);
        t_service(acysm_pkg::ACC_READ, 8'h01, 8'd100, 8'h00, 8'd1, 16'ha505,
            acysm_pkg::RESULT_BAD_PARAMS);
        t_service(acysm_pkg::ACC_WRITE, 8'h01, 8'd3, 8'h01, 8'd1, 16'ha506,
            acysm_pkg::RESULT_BAD_PARAMS);
        t_service(acysm_pkg::ACC_READ, 8'h01, 8'd3, 8'h00, 8'd121, 16'ha507,
            acysm_pkg::RESULT_BAD_PARAMS);
        t_status();
        close_out();
    end
endmodule
`default_nettype wire
